// ===== core/ocp_otp_pkg.sv
// Constants and types for the overcurrent and over-temperature protection block
package ocp_otp_pkg;
  localparam int CLK_NS = 8;
  localparam logic [6:0] PERIOD_CYC = 7'h7D;
  localparam logic [6:0] SET_CYC = 7'(PERIOD_CYC / 8);
  localparam int SAMPLE_NS = 75;
  localparam logic [6:0] SAMPLE_CYC = 7'((SAMPLE_NS + CLK_NS - 1) / CLK_NS);
  localparam int HICCUP_MS = 20;
  localparam int HICCUP_CYC = HICCUP_MS * 1000000 / CLK_NS;
  localparam logic [3:0] OC_MAX_COUNT = 4'h8;
  localparam logic [1:0] OC_STEP_DOWN = 2'h3;
  localparam logic [2:0] OC_STEP_UP = 3'h4;
  localparam logic [1:0] CAP_EIGHTH = 2'h3;
  localparam logic [7:0] DUTY_EIGHTH = 8'h20;
  localparam logic [7:0] OT_LIMIT_RST = 8'h7D;
  localparam logic [9:0] OT_HYST = 10'h019;
  localparam logic [8:0] TEMP_OFFSET = 9'h028;
  localparam logic [11:0] OC_WARN_RST = 12'h190;
  localparam logic [11:0] OC_FAULT_RST = 12'h1E0;
  localparam logic [7:0] BYTE_MAX = 8'hFF;

  typedef enum logic [1:0] {OT_IGNORE = 2'h0, OT_INHIBIT = 2'h1, OT_LATCH = 2'h2} ot_resp_t;
  localparam ot_resp_t OT_RESP_RST = OT_INHIBIT;
  localparam logic OC_RESP_HICCUP = 1'b0;
  localparam logic OC_RESP_LATCH = 1'b1;

  typedef enum logic [2:0] {ST_RUN = 3'b001, ST_HICCUP = 3'b010, ST_LATCH = 3'b100} prot_state_t;

  typedef struct packed {
    logic vcS1;
    logic vcS2;
    logic enS1;
    logic enS2;
    logic [6:0] periodCnt;
    logic setP;
    logic hs;
    logic convEn;
    prot_state_t mode;
    logic [21:0] hicCnt;
    logic [3:0] ocCount;
    logic [1:0] overRun;
    logic [2:0] underRun;
    logic [1:0] capLevel;
    logic otInhibit;
    logic ocWarn;
    logic ocFlag;
    logic otFlag;
    logic [11:0] iout;
    logic [7:0] curByte;
    logic [7:0] tempByte;
    logic [11:0] ocWarnLimit;
    logic [11:0] ocFaultLimit;
    logic [7:0] otLimit;
    ot_resp_t otResp;
    logic ocResp;
  } state_t;
endpackage

// ===== core/overcurrent_overtemp_protection.sv
// Overcurrent, duty step-down, hiccup and thermal shutdown logic of a buck regulator
`timescale 1ns/1ns

module overcurrent_overtemp_protection #(
  parameter int HICCUP_CYCLES = ocp_otp_pkg::HICCUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic valleyComp,
  input wire logic enablePin,
  input wire logic operationOn,
  input wire logic [7:0] dutyNominal,
  input wire logic [11:0] ioutAdc,
  input wire logic [7:0] tempAdcByte,
  input wire logic [11:0] wrData,
  input wire logic ocWarnLimitWr,
  input wire logic ocFaultLimitWr,
  input wire logic ocFaultResponseWr,
  input wire logic otFaultLimitWr,
  input wire logic otFaultResponseWr,
  input wire logic clearFaults,
  output logic setPulse,
  output logic hsOn,
  output logic convEnable,
  output logic [11:0] readIout,
  output logic [7:0] measuredCurrentByte,
  output logic [7:0] dieTemperatureByte,
  output logic [11:0] ocFaultThreshold,
  output logic ocWarn,
  output logic ocFaultStatus,
  output logic otFaultStatus,
  output logic [1:0] dutyCapLevel,
  output logic hiccupActive,
  output logic latchedOff
);

  localparam ocp_otp_pkg::state_t S_RST = '{
    mode: ocp_otp_pkg::ST_RUN,
    // Parked at the last count so the first edge after reset opens a full set pulse
    periodCnt: ocp_otp_pkg::PERIOD_CYC - 7'h1,
    otResp: ocp_otp_pkg::OT_RESP_RST,
    otLimit: ocp_otp_pkg::OT_LIMIT_RST,
    ocWarnLimit: ocp_otp_pkg::OC_WARN_RST,
    ocFaultLimit: ocp_otp_pkg::OC_FAULT_RST,
    ocResp: ocp_otp_pkg::OC_RESP_HICCUP,
    default: '0
  };

  ocp_otp_pkg::state_t s_r;
  ocp_otp_pkg::state_t s_nxt;

  logic run;
  logic sampleNow;
  logic ocHit;
  logic [7:0] onLen;
  logic [8:0] tempC;
  logic otTrip;
  logic otCool;
  logic [6:0] cntNext;

  // On-time in clocks for a cap level; level 0 leaves the nominal duty alone
  function automatic logic [7:0] capLen(input logic [1:0] level, input logic [7:0] nominal);
    logic [7:0] lim;
    lim = {1'b0, ocp_otp_pkg::PERIOD_CYC} >> level;
    capLen = (level != 2'd0 && nominal > lim) ? lim : nominal;
  endfunction

  assign run = s_r.enS2 & operationOn;
  assign sampleNow = (s_r.periodCnt == ocp_otp_pkg::SAMPLE_CYC) && s_r.convEn;
  // Only the comparator decides a trip; the digitized current plays no part
  assign ocHit = sampleNow && s_r.vcS2;
  assign onLen = capLen(s_r.capLevel, 8'((16'(ocp_otp_pkg::PERIOD_CYC) * 16'(dutyNominal)) >> 8));
  assign tempC = {1'b0, s_r.tempByte} + ocp_otp_pkg::TEMP_OFFSET;
  assign otTrip = tempC > {1'b0, s_r.otLimit};
  assign otCool = ({2'b00, s_r.otLimit} >= ({1'b0, tempC} + ocp_otp_pkg::OT_HYST));
  assign cntNext = (s_r.periodCnt == ocp_otp_pkg::PERIOD_CYC - 7'd1) ? 7'd0 : s_r.periodCnt + 7'd1;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.vcS1 = valleyComp;
    s_nxt.vcS2 = s_r.vcS1;
    s_nxt.enS1 = enablePin;
    s_nxt.enS2 = s_r.enS1;

    s_nxt.iout = ioutAdc;
    s_nxt.curByte = (ioutAdc[11:10] != 2'b00) ? ocp_otp_pkg::BYTE_MAX : ioutAdc[9:2];
    s_nxt.tempByte = tempAdcByte;
    s_nxt.ocWarn = s_r.iout > s_r.ocWarnLimit;

    if (ocWarnLimitWr)
    begin
      s_nxt.ocWarnLimit = wrData;
    end
    if (ocFaultLimitWr)
    begin
      s_nxt.ocFaultLimit = wrData;
    end
    if (ocFaultResponseWr)
    begin
      s_nxt.ocResp = wrData[0];
    end
    if (otFaultLimitWr)
    begin
      s_nxt.otLimit = wrData[7:0];
    end
    if (otFaultResponseWr)
    begin
      s_nxt.otResp = (wrData[1:0] == 2'h2) ? ocp_otp_pkg::OT_LATCH :
                     (wrData[1:0] == 2'h1) ? ocp_otp_pkg::OT_INHIBIT : ocp_otp_pkg::OT_IGNORE;
    end

    // Switching period timebase; set pulse and high-side pulse follow the counter
    s_nxt.periodCnt = cntNext;
    s_nxt.setP = cntNext < ocp_otp_pkg::SET_CYC;
    // A pulse only starts at set fall, never when enable comes up mid-period
    s_nxt.hs = s_r.convEn && (cntNext >= ocp_otp_pkg::SET_CYC) && (cntNext == ocp_otp_pkg::SET_CYC || s_r.hs)
               && ({1'b0, cntNext} < {1'b0, ocp_otp_pkg::SET_CYC} + onLen);

    // Over-temperature: inhibit drops out only on the response's own release
    if (s_r.otResp != ocp_otp_pkg::OT_IGNORE && otTrip)
    begin
      s_nxt.otInhibit = 1'b1;
    end
    else if (s_r.otResp == ocp_otp_pkg::OT_IGNORE)
    begin
      s_nxt.otInhibit = 1'b0;
    end
    else if (s_r.otResp == ocp_otp_pkg::OT_INHIBIT && otCool)
    begin
      s_nxt.otInhibit = 1'b0;
    end
    else if (s_r.otResp == ocp_otp_pkg::OT_LATCH && !run)
    begin
      s_nxt.otInhibit = 1'b0;
    end

    case (s_r.mode)
      ocp_otp_pkg::ST_RUN:
      begin
        if (ocHit)
        begin
          s_nxt.ocCount = s_r.ocCount + 4'd1;
          s_nxt.underRun = 3'd0;
          // Below an eighth there is nothing left to take away
          if (dutyNominal >= ocp_otp_pkg::DUTY_EIGHTH && s_r.capLevel != ocp_otp_pkg::CAP_EIGHTH)
          begin
            if (s_r.overRun == ocp_otp_pkg::OC_STEP_DOWN - 2'd1)
            begin
              s_nxt.capLevel = s_r.capLevel + 2'd1;
              s_nxt.overRun = 2'd0;
            end
            else
            begin
              s_nxt.overRun = s_r.overRun + 2'd1;
            end
          end
          if (s_r.ocCount == ocp_otp_pkg::OC_MAX_COUNT - 4'd1)
          begin
            s_nxt.hicCnt = '0;
            s_nxt.mode = (s_r.ocResp == ocp_otp_pkg::OC_RESP_LATCH) ? ocp_otp_pkg::ST_LATCH
                                                                    : ocp_otp_pkg::ST_HICCUP;
          end
        end
        else if (sampleNow)
        begin
          s_nxt.overRun = 2'd0;
          if (s_r.capLevel != 2'd0)
          begin
            if (s_r.underRun == ocp_otp_pkg::OC_STEP_UP - 3'd1)
            begin
              s_nxt.capLevel = s_r.capLevel - 2'd1;
              s_nxt.underRun = 3'd0;
            end
            else
            begin
              s_nxt.underRun = s_r.underRun + 3'd1;
            end
          end
        end
      end
      ocp_otp_pkg::ST_HICCUP:
      begin
        s_nxt.hicCnt = s_r.hicCnt + 22'd1;
        if (s_r.hicCnt == 22'(HICCUP_CYCLES - 1))
        begin
          s_nxt.mode = ocp_otp_pkg::ST_RUN;
          s_nxt.ocCount = 4'd0;
          s_nxt.capLevel = 2'd0;
          s_nxt.overRun = 2'd0;
          s_nxt.underRun = 3'd0;
        end
      end
      ocp_otp_pkg::ST_LATCH:
      begin
        if (!run)
        begin
          s_nxt.mode = ocp_otp_pkg::ST_RUN;
          s_nxt.ocCount = 4'd0;
          s_nxt.capLevel = 2'd0;
          s_nxt.overRun = 2'd0;
          s_nxt.underRun = 3'd0;
        end
      end
      default:
      begin
        s_nxt.mode = ocp_otp_pkg::ST_RUN;
      end
    endcase

    s_nxt.convEn = run && (s_r.mode == ocp_otp_pkg::ST_RUN) && !s_r.otInhibit;

    // Sticky fault flags; a new event outranks a clear in the same cycle
    s_nxt.ocFlag = (ocHit && s_r.ocCount == ocp_otp_pkg::OC_MAX_COUNT - 4'd1) || (s_r.ocFlag && !clearFaults);
    s_nxt.otFlag = (otTrip && s_r.otResp != ocp_otp_pkg::OT_IGNORE) || (s_r.otFlag && !clearFaults);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= S_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign setPulse = s_r.setP;
  assign hsOn = s_r.hs;
  assign convEnable = s_r.convEn;
  assign readIout = s_r.iout;
  assign measuredCurrentByte = s_r.curByte;
  assign dieTemperatureByte = s_r.tempByte;
  assign ocFaultThreshold = s_r.ocFaultLimit;
  assign ocWarn = s_r.ocWarn;
  assign ocFaultStatus = s_r.ocFlag;
  assign otFaultStatus = s_r.otFlag;
  assign dutyCapLevel = s_r.capLevel;
  assign hiccupActive = (s_r.mode == ocp_otp_pkg::ST_HICCUP);
  assign latchedOff = (s_r.mode == ocp_otp_pkg::ST_LATCH);

  property p_set_width;
    @(posedge clk) disable iff (rst)
    $rose(setPulse) |-> setPulse[*8] ##1 setPulse[*7] ##1 !setPulse;
  endproperty
  a_set_width: assert property (p_set_width) else $error("set pulse width wrong");

  property p_hs_start;
    @(posedge clk) disable iff (rst)
    hsOn |-> !setPulse && (!$past(hsOn) -> $past(setPulse));
  endproperty
  a_hs_start: assert property (p_hs_start) else $error("high-side pulse not at set fall");

  property p_oc_to_hiccup;
    @(posedge clk) disable iff (rst)
    (ocHit && s_r.mode == ocp_otp_pkg::ST_RUN && s_r.ocCount == 4'd7 && s_r.ocResp == ocp_otp_pkg::OC_RESP_HICCUP)
      |=> hiccupActive ##1 !convEnable;
  endproperty
  a_oc_to_hiccup: assert property (p_oc_to_hiccup) else $error("eighth trip did not start hiccup");

  property p_hiccup_end;
    @(posedge clk) disable iff (rst)
    (hiccupActive && s_r.hicCnt == 22'(HICCUP_CYCLES - 1)) |=> !hiccupActive && s_r.ocCount == 4'd0;
  endproperty
  a_hiccup_end: assert property (p_hiccup_end) else $error("hiccup did not end and clear");

  property p_hiccup_off;
    @(posedge clk) disable iff (rst)
    $past(hiccupActive) |-> !convEnable && !hsOn;
  endproperty
  a_hiccup_off: assert property (p_hiccup_off) else $error("converting during hiccup");

  property p_cap_down;
    @(posedge clk) disable iff (rst)
    (dutyCapLevel > $past(dutyCapLevel)) |-> $past(ocHit) && $past(s_r.overRun) == 2'd2;
  endproperty
  a_cap_down: assert property (p_cap_down) else $error("cap stepped without three trips");

  property p_cap_up;
    @(posedge clk) disable iff (rst)
    (dutyCapLevel < $past(dutyCapLevel) && !$past(hiccupActive) && !$past(latchedOff))
      |-> $past(sampleNow) && !$past(ocHit) && $past(s_r.underRun) == 3'd3;
  endproperty
  a_cap_up: assert property (p_cap_up) else $error("cap raised without four clean cycles");

  property p_low_duty;
    @(posedge clk) disable iff (rst)
    (ocHit && dutyNominal < ocp_otp_pkg::DUTY_EIGHTH && !hiccupActive && !latchedOff) |=> $stable(dutyCapLevel);
  endproperty
  a_low_duty: assert property (p_low_duty) else $error("duty reduced below an eighth");

  property p_ot_default;
    @(posedge clk)
    rst |=> s_r.otLimit == 8'd125 && s_r.otResp == ocp_otp_pkg::OT_INHIBIT;
  endproperty
  a_ot_default: assert property (p_ot_default) else $error("thermal defaults wrong after reset");

  property p_ot_hold;
    @(posedge clk) disable iff (rst)
    (s_r.otInhibit && s_r.otResp == ocp_otp_pkg::OT_INHIBIT && !otCool && !otFaultResponseWr)
      |=> s_r.otInhibit ##1 !convEnable;
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("restart before hysteresis");

  property p_latch_hold;
    @(posedge clk) disable iff (rst)
    (latchedOff && run) |=> latchedOff;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched shutdown released");

  property p_oc_latch;
    @(posedge clk) disable iff (rst)
    (ocHit && s_r.mode == ocp_otp_pkg::ST_RUN && s_r.ocCount == 4'h7 && s_r.ocResp == ocp_otp_pkg::OC_RESP_LATCH)
      |=> latchedOff ##1 !convEnable;
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("eighth trip did not latch off");

  property p_ot_trip;
    @(posedge clk) disable iff (rst)
    (otTrip && s_r.otResp != ocp_otp_pkg::OT_IGNORE) |=> s_r.otInhibit ##1 !convEnable;
  endproperty
  a_ot_trip: assert property (p_ot_trip) else $error("over-temperature did not stop conversion");

endmodule // overcurrent_overtemp_protection

// ===== verif/power_stage_model.sv
// Behavioural valley-current comparator of the power stage
`timescale 1ns/1ns
module power_stage_model (
  input wire logic clk,
  input wire logic overload,
  output logic valleyComp
);
  initial valleyComp = 1'b0;
  // Moves on the rising edge after the bench's change, so the latency is fixed
  always @(posedge clk)
  begin
    valleyComp <= overload;
  end
endmodule // power_stage_model

// ===== verif/overcurrent_overtemp_protection_tb.sv
// Self-checking testbench of the protection block
`timescale 1ns/1ns
module overcurrent_overtemp_protection_tb;
  localparam int PER = 125;
  localparam int HIC = 50;
  logic clk, rst, overload, valleyComp, enablePin, operationOn, clearFaults;
  logic setPulse, hsOn, convEnable, ocWarn, ocFaultStatus, otFaultStatus, hiccupActive, latchedOff;
  logic [7:0] dutyNominal, tempAdcByte, measuredCurrentByte, dieTemperatureByte;
  logic [11:0] ioutAdc, wrData, readIout, ocFaultThreshold;
  logic [4:0] wrStb;
  logic [1:0] dutyCapLevel;
  int fail_count = 0;
  int checks_done = 0;

  power_stage_model i_power_stage_model (.clk, .overload, .valleyComp);

  overcurrent_overtemp_protection #(.HICCUP_CYCLES(HIC)) i_overcurrent_overtemp_protection (
    .clk, .rst, .valleyComp, .enablePin, .operationOn, .dutyNominal, .ioutAdc, .tempAdcByte, .wrData,
    .ocWarnLimitWr(wrStb[0]), .ocFaultLimitWr(wrStb[1]), .ocFaultResponseWr(wrStb[2]),
    .otFaultLimitWr(wrStb[3]), .otFaultResponseWr(wrStb[4]), .clearFaults, .setPulse, .hsOn,
    .convEnable, .readIout, .measuredCurrentByte, .dieTemperatureByte, .ocFaultThreshold, .ocWarn,
    .ocFaultStatus, .otFaultStatus, .dutyCapLevel, .hiccupActive, .latchedOff
  );

  initial
  begin
    clk = 1'b1;
    forever #4 clk = ~clk;
  end

  task waitc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task chk(input string nm, input logic [11:0] e, input logic [11:0] s);
    checks_done++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask

  task final_report();
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task do_reset();
    rst = 1'b1;
    overload = 1'b0;
    enablePin = 1'b1;
    operationOn = 1'b1;
    clearFaults = 1'b0;
    dutyNominal = 8'h80;
    ioutAdc = 12'h000;
    tempAdcByte = 8'h28;
    wrData = 12'h000;
    wrStb = 5'h00;
    waitc(3);
    rst = 1'b0;
    waitc(1);
  endtask

  task wr(input int i, input logic [11:0] d);
    wrData = d;
    wrStb[i] = 1'b1;
    waitc(1);
    wrStb = 5'h00;
    waitc(2);
  endtask

  // Start of a period, sampled on the falling edge after set rises
  task align();
    @(posedge setPulse);
    waitc(1);
  endtask

  task t_period();
    int n;
    do_reset();
    align();
    chk("hsDuringSet", 0, hsOn);
    n = 0;
    while (setPulse === 1'b1 && n < 200)
    begin
      n++;
      waitc(1);
    end
    chk("setLen", 15, n);
    chk("hsAfterSet", 1, hsOn);
    while (setPulse !== 1'b1 && n < 400)
    begin
      n++;
      waitc(1);
    end
    chk("period", PER, n);
  endtask

  task t_telemetry();
    do_reset();
    ioutAdc = 12'h3FF;
    tempAdcByte = 8'h55;
    waitc(3);
    chk("readIout", 12'h3FF, readIout);
    chk("curByte", 12'h0FF, measuredCurrentByte);
    chk("tempByte", 12'h055, dieTemperatureByte);
    chk("warnHigh", 1, ocWarn);
    ioutAdc = 12'h190;
    waitc(3);
    chk("warnEdge", 0, ocWarn);
    ioutAdc = 12'h104;
    waitc(3);
    chk("curByte", 12'h041, measuredCurrentByte);
    ioutAdc = 12'hFFF;
    waitc(3 * PER);
    chk("ocStatus", 0, ocFaultStatus);
    chk("hiccup", 0, hiccupActive);
    chk("faultThr", 12'h1E0, ocFaultThreshold);
    wr(1, 12'h123);
    chk("faultThr", 12'h123, ocFaultThreshold);
    wr(0, 12'h100);
    ioutAdc = 12'h101;
    waitc(3);
    chk("warnNewLimit", 1, ocWarn);
  endtask

  task t_step();
    do_reset();
    dutyNominal = 8'hC0;
    waitc(PER);
    align();
    overload = 1'b1;
    waitc(245);
    chk("capTwoTrips", 0, dutyCapLevel);
    waitc(25);
    chk("capThreeTrips", 1, dutyCapLevel);
    overload = 1'b0;
    waitc(3 * PER);
    chk("capThreeClean", 1, dutyCapLevel);
    waitc(PER);
    chk("capFourClean", 0, dutyCapLevel);
  endtask

  task t_hiccup();
    int n;
    do_reset();
    dutyNominal = 8'h10;
    waitc(PER);
    align();
    overload = 1'b1;
    waitc(7 * PER - 4);
    chk("hiccupSeven", 0, hiccupActive);
    chk("capLowDuty", 0, dutyCapLevel);
    n = 0;
    while (convEnable === 1'b1 && n < 40)
    begin
      n++;
      waitc(1);
    end
    chk("hiccupEight", 1, hiccupActive);
    n = 0;
    while (convEnable === 1'b0 && n < 300)
    begin
      n++;
      overload = 1'b0;
      waitc(1);
    end
    chk("hiccupLen", HIC, n);
    chk("hiccupEnd", 0, hiccupActive);
  endtask

  task t_latch();
    do_reset();
    wr(2, 12'h001);
    waitc(PER);
    align();
    overload = 1'b1;
    waitc(8 * PER);
    chk("latched", 1, latchedOff);
    chk("convLatched", 0, convEnable);
    overload = 1'b0;
    waitc(300);
    chk("stillLatched", 1, latchedOff);
    chk("ocStatus", 1, ocFaultStatus);
    clearFaults = 1'b1;
    waitc(1);
    clearFaults = 1'b0;
    waitc(2);
    chk("ocCleared", 0, ocFaultStatus);
    operationOn = 1'b0;
    waitc(3);
    operationOn = 1'b1;
    waitc(5);
    chk("released", 0, latchedOff);
    chk("convBack", 1, convEnable);
  endtask

  task t_thermal();
    do_reset();
    tempAdcByte = 8'd85;
    waitc(6);
    chk("otAtLimit", 1, convEnable);
    tempAdcByte = 8'd86;
    waitc(4);
    chk("otOver", 0, convEnable);
    chk("otStatus", 1, otFaultStatus);
    tempAdcByte = 8'd61;
    waitc(4);
    chk("otHyst", 0, convEnable);
    tempAdcByte = 8'd60;
    waitc(6);
    chk("otRestart", 1, convEnable);
    wr(4, 12'h000);
    tempAdcByte = 8'd86;
    waitc(4);
    chk("otIgnore", 1, convEnable);
    wr(4, 12'h002);
    waitc(2);
    chk("otLatch", 0, convEnable);
    tempAdcByte = 8'd0;
    waitc(4);
    chk("otLatchHold", 0, convEnable);
    enablePin = 1'b0;
    waitc(4);
    enablePin = 1'b1;
    waitc(6);
    chk("otLatchFree", 1, convEnable);
    wr(4, 12'h001);
    wr(3, 12'd100);
    tempAdcByte = 8'd61;
    waitc(4);
    chk("otNewLimit", 0, convEnable);
    wr(4, 12'h003);
    waitc(1);
    chk("otCodeThree", 1, convEnable);
  endtask

  initial
  begin
    #320000;
    fail_count++;
    final_report();
  end

  initial
  begin
    t_period();
    t_telemetry();
    t_step();
    t_hiccup();
    t_latch();
    t_thermal();
    final_report();
  end
endmodule // overcurrent_overtemp_protection_tb
